//--- dv/maaf_top_asserts.sv
/*
  concurrent checks on the ports of the add/logic datapath top.
  assumes one clock, async active-high reset, bound onto maaf_top.
*/
`timescale 1ns/1ps
`default_nettype none

module maaf_top_asserts #(
  parameter int FILE_DEPTH = 64,
  parameter int PAGE_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire maaf_pkg::maaf_op_type op_code,
  input wire logic [7:0] imm_data,
  input wire logic [3:0] page_addr,
  input wire logic wdt_timeout_pin,
  input wire logic [7:0] work_register,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic digit_carry_flag,
  input wire logic power_down_flag,
  input wire logic time_out_flag,
  input wire logic halted,
  input wire logic op_done,
  input wire logic op_reject
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic take;
  assign take = op_valid && op_ready;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  done_after_take_a: assert property (take |=> op_done)
    else $error("no op_done after a taken op");
  refused_no_done_a: assert property (!op_ready |=> !op_done)
    else $error("op_done while not ready");
  halt_flags_a: assert property (take && op_code == maaf_pkg::op_halt |=> halted && !power_down_flag)
    else $error("halt did not clear power-down flag");
  wdt_clear_pd_a: assert property (take && op_code == maaf_pkg::op_watchdog_clear |=> power_down_flag)
    else $error("watchdog clear did not set power-down flag");
  // pin is async, three sync stages give some slack
  timeout_clears_a: assert property ($rose(wdt_timeout_pin) |-> ##[1:5] !time_out_flag)
    else $error("timeout did not clear time-out flag");
  imm_add_sum_a: assert property (take && op_code == maaf_pkg::op_imm_add |=>
    {carry_flag, work_register} == {1'b0, $past(work_register)} + {1'b0, $past(imm_data)})
    else $error("immediate add sum or carry wrong");
  imm_adc_sum_a: assert property (take && op_code == maaf_pkg::op_imm_add_with_carry |=>
    {carry_flag, work_register} ==
    {1'b0, $past(work_register)} + {1'b0, $past(imm_data)} + $past(carry_flag))
    else $error("immediate add with carry wrong");
  imm_digit_a: assert property (take && op_code == maaf_pkg::op_imm_add |=>
    digit_carry_flag == (({1'b0, $past(work_register[3:0])} + {1'b0, $past(imm_data[3:0])}) > 5'h0F))
    else $error("digit carry wrong");
  zero_tracks_a: assert property (take && op_code == maaf_pkg::op_imm_add |=>
    zero_flag == (work_register == 8'h00))
    else $error("zero flag wrong");
  and_keeps_carry_a: assert property (take && op_code == maaf_pkg::op_reg_and |=>
    $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("and changed carry flags");
  clear_keeps_flags_a: assert property (take && op_code == maaf_pkg::op_bit_clear |=>
    $stable({carry_flag, zero_flag, digit_carry_flag}))
    else $error("bit clear changed flags");
  ctrl_reject_a: assert property (take && op_code == maaf_pkg::op_ctrl_page_write |=>
    op_reject == ($past(page_addr) < 4'h5))
    else $error("control page reject wrong");
  sfr_accept_a: assert property (take && op_code == maaf_pkg::op_sfr_page_write |=> !op_reject)
    else $error("special page write rejected");

  c_halt: cover property (take && op_code == maaf_pkg::op_halt);
  c_wake: cover property ($fell(halted));
  c_reject: cover property (op_reject);
endmodule : maaf_top_asserts

bind maaf_top maaf_top_asserts #(.FILE_DEPTH(FILE_DEPTH), .PAGE_DEPTH(PAGE_DEPTH)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .op_valid(op_valid), .op_ready(op_ready),
  .op_code(op_code), .imm_data(imm_data), .page_addr(page_addr),
  .wdt_timeout_pin(wdt_timeout_pin), .work_register(work_register),
  .carry_flag(carry_flag), .zero_flag(zero_flag), .digit_carry_flag(digit_carry_flag),
  .power_down_flag(power_down_flag), .time_out_flag(time_out_flag), .halted(halted),
  .op_done(op_done), .op_reject(op_reject)
);

`default_nettype wire

//--- dv/tb.sv
/*
  self-checking bench for maaf_top with an integer model of the datapath.
  assumes the hw package and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  maaf_pkg::maaf_op_type op_code = maaf_pkg::op_nop;
  logic [5:0] file_addr = 6'h00;
  logic dest_sel = 1'b0;
  logic [7:0] imm_data = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [3:0] page_addr = 4'h0;
  logic wdt_timeout_pin = 1'b0;
  logic wake_pin = 1'b0;
  logic op_ready, carry_flag, zero_flag, digit_carry_flag, power_down_flag, time_out_flag;
  logic halted, op_done, op_reject;
  logic [7:0] work_register, result_data;
  int mismatches = 0;
  int checked = 0;
  int mw, mc, mz, mdc, mpd, mto, mres;
  int mf[64];
  int mctl[16];
  int msfr[16];
  maaf_pkg::maaf_op_type rops[10] = '{maaf_pkg::op_reg_add_with_carry, maaf_pkg::op_reg_add,
    maaf_pkg::op_imm_add_with_carry, maaf_pkg::op_imm_add, maaf_pkg::op_reg_sub,
    maaf_pkg::op_reg_sub_with_borrow, maaf_pkg::op_reg_and, maaf_pkg::op_bit_clear,
    maaf_pkg::op_ctrl_page_write, maaf_pkg::op_sfr_page_read};

  always #25 sys_clk = ~sys_clk;

  maaf_top u_dut (.sys_clk(sys_clk), .reset(reset), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .file_addr(file_addr), .dest_sel(dest_sel), .imm_data(imm_data),
    .bit_sel(bit_sel), .page_addr(page_addr), .wdt_timeout_pin(wdt_timeout_pin),
    .wake_pin(wake_pin), .work_register(work_register), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .digit_carry_flag(digit_carry_flag),
    .power_down_flag(power_down_flag), .time_out_flag(time_out_flag), .halted(halted),
    .op_done(op_done), .op_reject(op_reject), .result_data(result_data));

  // ----------------------------------------
  // model and checks
  // ----------------------------------------
  task automatic close_out();
    $display("counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [7:0] seen, input int exp);
    checked++;
    if (seen !== exp[7:0]) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", name, exp[7:0], seen);
    end
  endtask : chk

  task automatic mreset();
    {mw, mc, mz, mdc, mres} = '0;
    mpd = 1;
    mto = 1;
    foreach (mf[i]) mf[i] = 0;
    foreach (mctl[i]) begin
      mctl[i] = 0;
      msfr[i] = 0;
    end
  endtask : mreset

  task automatic chk_state(input int done, input int rej, input int has_res);
    chk("op_done", op_done, done);
    chk("op_reject", op_reject, rej);
    chk("work", work_register, mw);
    chk("carry", carry_flag, mc);
    chk("zero", zero_flag, mz);
    chk("digit", digit_carry_flag, mdc);
    chk("power_down", power_down_flag, mpd);
    chk("time_out", time_out_flag, mto);
    if (has_res) chk("result", result_data, mres);
  endtask : chk_state

  // subtraction enters as a + ~b + cin, so carry 1 means no borrow
  task automatic arith(input int a, input int b, input int cin, input int d, input int fa);
    int s;
    s = a + b + cin;
    mdc = ((a & 15) + (b & 15) + cin) > 15;
    mc = s > 255;
    mres = s & 255;
    mz = mres == 0;
    if (d == 1) mf[fa] = mres; else mw = mres;
  endtask : arith

  task automatic do_op(input maaf_pkg::maaf_op_type op, input int fa, input int d,
                       input int imm, input int bs, input int pa);
    int rej;
    int res;
    rej = 0;
    res = 0;
    op_valid = 1'b1;
    op_code = op;
    file_addr = fa[5:0];
    dest_sel = d[0];
    imm_data = imm[7:0];
    bit_sel = bs[2:0];
    page_addr = pa[3:0];
    @(negedge sys_clk);
    res = op <= maaf_pkg::op_reg_and;
    case (op)
      maaf_pkg::op_reg_add_with_carry: arith(mf[fa], mw, mc, d, fa);
      maaf_pkg::op_reg_add: arith(mw, mf[fa], 0, d, fa);
      maaf_pkg::op_imm_add_with_carry: arith(mw, imm, mc, 0, fa);
      maaf_pkg::op_imm_add: arith(mw, imm, 0, 0, fa);
      maaf_pkg::op_reg_sub: arith(mf[fa], 255 - mw, 1, d, fa);
      maaf_pkg::op_reg_sub_with_borrow: arith(mf[fa], 255 - mw, mc, d, fa);
      maaf_pkg::op_reg_and: begin
        mres = mw & mf[fa];
        mz = mres == 0;
        if (d == 1) mf[fa] = mres; else mw = mres;
      end
      maaf_pkg::op_bit_clear: mf[fa] &= ~(1 << bs);
      maaf_pkg::op_watchdog_clear: {mpd, mto} = {32'd1, 32'd1};
      maaf_pkg::op_halt: {mpd, mto} = {32'd0, 32'd1};
      maaf_pkg::op_ctrl_page_write: begin
        rej = pa < 5;
        if (!rej) mctl[pa] = mw;
      end
      maaf_pkg::op_ctrl_page_read: begin
        rej = pa < 5;
        if (!rej) mw = mctl[pa];
      end
      maaf_pkg::op_sfr_page_write: msfr[pa] = mw;
      maaf_pkg::op_sfr_page_read: mw = msfr[pa];
      default: res = 0;
    endcase
    chk_state(1, rej, res);
  endtask : do_op

  task automatic idle(input int n);
    op_valid = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask : idle

  task automatic wait_low(input string name, input int use_to);
    int n;
    for (n = 0; n < 10 && (use_to ? time_out_flag : halted) !== 1'b0; n++) @(negedge sys_clk);
    if (n == 10) begin
      mismatches++;
      $display("unexpected %s expected 0 seen %b", name, use_to ? time_out_flag : halted);
      close_out();
    end
  endtask : wait_low

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(71324));
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    mreset();
    chk_state(0, 0, 1);
    chk("ready", op_ready, 1);
    $display("test reset done");
    // wrap to zero, then last file register, both destinations
    do_op(maaf_pkg::op_imm_add, 0, 0, 8'hFF, 0, 0);
    do_op(maaf_pkg::op_imm_add, 0, 0, 8'h01, 0, 0);
    do_op(maaf_pkg::op_imm_add_with_carry, 0, 0, 8'h11, 0, 0);
    do_op(maaf_pkg::op_reg_add, 6'h3F, 1, 0, 0, 0);
    do_op(maaf_pkg::op_reg_add_with_carry, 6'h3F, 0, 0, 0, 0);
    do_op(maaf_pkg::op_reg_sub, 6'h3F, 1, 0, 0, 0);
    do_op(maaf_pkg::op_reg_sub_with_borrow, 6'h3F, 1, 0, 0, 0);
    do_op(maaf_pkg::op_reg_and, 6'h3F, 0, 0, 0, 0);
    $display("test adds done");
    do_op(maaf_pkg::op_imm_add, 0, 0, (255 - mw) & 255, 0, 0);
    // file 5 starts at zero; load all ones so every bit clear shows
    do_op(maaf_pkg::op_reg_add, 5, 1, 0, 0, 0);
    do_op(maaf_pkg::op_reg_and, 5, 1, 0, 0, 0);
    for (int b = 0; b < 8; b++) begin
      do_op(maaf_pkg::op_bit_clear, 5, 0, 0, b, 0);
      do_op(maaf_pkg::op_reg_add, 5, 0, 0, 0, 0);
    end
    $display("test bit clear done");
    for (int p = 0; p < 16; p++) begin
      do_op(maaf_pkg::op_imm_add, 0, 0, 8'h13, 0, 0);
      do_op(maaf_pkg::op_ctrl_page_write, 0, 0, 0, 0, p);
      do_op(maaf_pkg::op_sfr_page_write, 0, 0, 0, 0, p);
    end
    for (int p = 0; p < 16; p++) begin
      do_op(maaf_pkg::op_ctrl_page_read, 0, 0, 0, 0, p);
      do_op(maaf_pkg::op_sfr_page_read, 0, 0, 0, 0, p);
    end
    $display("test pages done");
    do_op(maaf_pkg::op_halt, 0, 0, 0, 0, 0);
    op_code = maaf_pkg::op_imm_add;
    repeat (2) @(negedge sys_clk);
    chk("ready", op_ready, 0);
    chk_state(0, 0, 0);
    idle(1);
    wake_pin = 1'b1;
    wait_low("halted", 0);
    wake_pin = 1'b0;
    chk("ready", op_ready, 1);
    $display("test halt done");
    wdt_timeout_pin = 1'b1;
    wait_low("time_out", 1);
    mto = 0;
    wdt_timeout_pin = 1'b0;
    chk_state(0, 0, 0);
    do_op(maaf_pkg::op_watchdog_clear, 0, 0, 0, 0, 0);
    do_op(maaf_pkg::op_halt, 0, 0, 0, 0, 0);
    idle(2);
    wdt_timeout_pin = 1'b1;
    wait_low("time_out", 1);
    mto = 0;
    wdt_timeout_pin = 1'b0;
    idle(1);
    chk("halted", halted, 0);
    chk_state(0, 0, 0);
    do_op(maaf_pkg::op_watchdog_clear, 0, 0, 0, 0, 0);
    $display("test watchdog done");
    repeat (400) do_op(rops[$urandom_range(9)], $urandom_range(63), $urandom_range(1),
      $urandom_range(255), $urandom_range(7), $urandom_range(15));
    idle(1);
    $display("test random done");
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    mreset();
    chk_state(0, 0, 1);
    $display("test second reset done");
    close_out();
  end
endmodule : tb

`default_nettype wire

//--- hw/maaf_adder.sv
/*
  8-bit adder with carry in, giving sum, digit carry and carry out.
  assumes subtraction is fed as a + ~b + carry by the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module maaf_adder #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] b_in,
  input wire logic carry_in,
  output logic [WIDTH-1:0] sum_out,
  output logic digit_carry_out,
  output logic carry_out
);
  localparam int HALF = WIDTH / 2;
  logic [WIDTH:0] full_sum;
  logic [HALF:0] low_sum;

  // ----------------------------------------
  // add
  // ----------------------------------------
  // no-borrow reads as carry set, so one adder serves both directions
  assign full_sum = {1'b0, a_in} + {1'b0, b_in} + {{WIDTH{1'b0}}, carry_in};
  assign low_sum = {1'b0, a_in[HALF-1:0]} + {1'b0, b_in[HALF-1:0]}
                 + {{HALF{1'b0}}, carry_in};
  assign sum_out = full_sum[WIDTH-1:0];
  assign carry_out = full_sum[WIDTH];
  assign digit_carry_out = low_sum[HALF];

endmodule : maaf_adder

`default_nettype wire

//--- hw/maaf_pkg.sv
/*
  constants, opcode and mode types for the 8-bit add/logic datapath.
  assumes one core clock; nothing else is shared with other blocks.
*/
package maaf_pkg;

  // ----------------------------------------
  // widths and address ranges
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int FILE_AW = 6;
  localparam int PAGE_AW = 4;
  localparam logic [5:0] FILE_FIRST = 6'h00;
  localparam logic [5:0] FILE_LAST = 6'h3F;
  localparam logic [3:0] CTRL_PAGE_FIRST = 4'h5;
  localparam logic [3:0] CTRL_PAGE_LAST = 4'hF;
  localparam logic [3:0] SFR_PAGE_FIRST = 4'h0;
  localparam logic [3:0] SFR_PAGE_LAST = 4'hF;
  localparam int DIGIT_BIT = 4;

  // ----------------------------------------
  // reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic ARITH_FLAG_RESET = 1'b0;
  localparam logic POWER_DOWN_RESET = 1'b1;
  localparam logic TIME_OUT_RESET = 1'b1;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam int OP_CYCLES = 1;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    op_nop,
    op_reg_add_with_carry,
    op_reg_add,
    op_imm_add_with_carry,
    op_imm_add,
    op_reg_sub,
    op_reg_sub_with_borrow,
    op_reg_and,
    op_bit_clear,
    op_watchdog_clear,
    op_halt,
    op_ctrl_page_write,
    op_ctrl_page_read,
    op_sfr_page_write,
    op_sfr_page_read
  } maaf_op_type;

  typedef enum logic {
    mode_run,
    mode_halt
  } maaf_mode_type;

  function automatic logic maaf_is_zero(input logic [7:0] value);
    maaf_is_zero = (value == 8'h00);
  endfunction : maaf_is_zero

endpackage : maaf_pkg

//--- hw/maaf_regfile.sv
/*
  primary file-register page: flip-flop storage, one write port, one read.
  assumes the user drives one address per cycle through the interface.
*/
`timescale 1ns/1ps
`default_nettype none

module maaf_regfile #(
  parameter int DEPTH = 64
) (
  input wire logic sys_clk,
  input wire logic reset,
  maaf_rf_if.owner rf
);
  logic [7:0] store_ff [DEPTH];

  // ----------------------------------------
  // read
  // ----------------------------------------
  // read is combinational so a read-modify-write fits one cycle
  assign rf.rd_data = store_ff[rf.rd_addr];

  // ----------------------------------------
  // write
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        store_ff[i] <= maaf_pkg::FILE_RESET;
      end
    end else if (rf.wr_en) begin
      store_ff[rf.wr_addr] <= rf.wr_data;
    end
  end

endmodule : maaf_regfile

`default_nettype wire

//--- hw/maaf_rf_if.sv
/*
  read and write port bundle between the datapath and its file registers.
  assumes a combinational read and a write taken on the clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

interface maaf_rf_if;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;

  modport owner (
    input rd_addr,
    output rd_data,
    input wr_en,
    input wr_addr,
    input wr_data
  );

  modport user (
    output rd_addr,
    input rd_data,
    output wr_en,
    output wr_addr,
    output wr_data
  );
endinterface : maaf_rf_if

`default_nettype wire

//--- hw/maaf_top.sv
/*
  arithmetic and logic datapath of a small 8-bit core with its status flags.
  assumes the decoder presents one operation per cycle with op_valid, and
  that watchdog timeout and wake arrive as asynchronous pins.
*/
// How it works
// - carry set on add carry-out or no subtract borrow, else cleared
// - destination select 0 writes work register, 1 writes the file register
// - power-down flag is 1 after reset and watchdog clear, 0 after halt
// - time-out flag 1 after reset, watchdog clear or halt; 0 on timeout
// - file-register operand addresses primary page 0x00 to 0x3F
// - control page moves accept only locations 0x5 through 0xF
// - special-function page moves accept locations 0x0 through 0xF
// - register add-with-carry sums file, work and carry; sets Z, DC, C
// - register add sums work and file without carry; sets Z, DC, C
// - immediate add-with-carry puts work plus immediate plus carry in work
// - immediate add puts work plus immediate in work, carry ignored
// - register AND writes work AND file to destination; only Z changes
// - bit clear zeroes one chosen bit of a file register; no flags
`timescale 1ns/1ps
`default_nettype none

module maaf_top #(
  parameter int FILE_DEPTH = 64,
  parameter int PAGE_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic op_valid,
  output logic op_ready,
  input wire maaf_pkg::maaf_op_type op_code,
  input wire logic [5:0] file_addr,
  input wire logic dest_sel,
  input wire logic [7:0] imm_data,
  input wire logic [2:0] bit_sel,
  input wire logic [3:0] page_addr,
  input wire logic wdt_timeout_pin,
  input wire logic wake_pin,
  output logic [7:0] work_register,
  output logic carry_flag,
  output logic zero_flag,
  output logic digit_carry_flag,
  output logic power_down_flag,
  output logic time_out_flag,
  output logic halted,
  output logic op_done,
  output logic op_reject,
  output logic [7:0] result_data
);

  // ----------------------------------------
  // storage and wiring
  // ----------------------------------------
  maaf_rf_if rf_bus ();

  logic [7:0] work_ff;
  logic carry_ff;
  logic zero_ff;
  logic digit_carry_ff;
  logic power_down_ff;
  logic time_out_ff;
  logic done_ff;
  logic reject_ff;
  logic [7:0] result_ff;
  logic [7:0] ctrl_page_ff [PAGE_DEPTH];
  logic [7:0] sfr_page_ff [PAGE_DEPTH];
  maaf_pkg::maaf_mode_type mode_ff;
  maaf_pkg::maaf_mode_type nxt_mode;

  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] sync3_ff;
  logic [1:0] pin_level_ff;
  logic [1:0] nxt_pin_level;
  logic timeout_event;
  logic wake_event;

  logic take;
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic add_cin;
  logic [7:0] add_sum;
  logic add_dc;
  logic add_c;

  logic [7:0] nxt_result;
  logic wr_work;
  logic wr_file;
  logic wr_ctrl;
  logic wr_sfr;
  logic upd_arith;
  logic upd_zero;
  logic bad_addr;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  maaf_regfile #(
    .DEPTH(FILE_DEPTH)
  ) u_regfile (
    .sys_clk(sys_clk),
    .reset(reset),
    .rf(rf_bus.owner)
  );

  maaf_adder #(
    .WIDTH(maaf_pkg::DATA_W)
  ) u_adder (
    .a_in(add_a),
    .b_in(add_b),
    .carry_in(add_cin),
    .sum_out(add_sum),
    .digit_carry_out(add_dc),
    .carry_out(add_c)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 0 watchdog timeout, bit 1 wake; a change counts once stages 2 and 3 agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      sync3_ff <= 2'h0;
    end else begin
      sync1_ff <= {wake_pin, wdt_timeout_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_pin_level[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : pin_level_ff[i];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_level_ff <= 2'h0;
    end else begin
      pin_level_ff <= nxt_pin_level;
    end
  end

  // rising edges only; a held timeout level fires once
  assign timeout_event = nxt_pin_level[0] & ~pin_level_ff[0];
  assign wake_event = nxt_pin_level[1] & ~pin_level_ff[1];

  // ----------------------------------------
  // operand select and decode
  // ----------------------------------------
  assign op_ready = (mode_ff == maaf_pkg::mode_run);
  assign take = op_valid & op_ready;
  assign rf_bus.rd_addr = file_addr;

  always_comb begin
    add_a = work_ff;
    add_b = rf_bus.rd_data;
    add_cin = 1'b0;
    nxt_result = add_sum;
    wr_work = 1'b0;
    wr_file = 1'b0;
    wr_ctrl = 1'b0;
    wr_sfr = 1'b0;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    bad_addr = 1'b0;
    case (op_code)
      maaf_pkg::op_reg_add_with_carry: begin
        add_cin = carry_ff;
        upd_arith = 1'b1;
        wr_work = (dest_sel == maaf_pkg::DEST_WORK);
        wr_file = (dest_sel == maaf_pkg::DEST_FILE);
      end
      maaf_pkg::op_reg_add: begin
        add_cin = 1'b0;
        upd_arith = 1'b1;
        wr_work = (dest_sel == maaf_pkg::DEST_WORK);
        wr_file = (dest_sel == maaf_pkg::DEST_FILE);
      end
      maaf_pkg::op_imm_add_with_carry: begin
        add_b = imm_data;
        add_cin = carry_ff;
        upd_arith = 1'b1;
        wr_work = 1'b1;
      end
      maaf_pkg::op_imm_add: begin
        add_b = imm_data;
        add_cin = 1'b0;
        upd_arith = 1'b1;
        wr_work = 1'b1;
      end
      maaf_pkg::op_reg_sub, maaf_pkg::op_reg_sub_with_borrow: begin
        // file minus work as file + ~work + 1, or + carry for chained borrow
        add_a = rf_bus.rd_data;
        add_b = ~work_ff;
        add_cin = (op_code == maaf_pkg::op_reg_sub) ? 1'b1 : carry_ff;
        upd_arith = 1'b1;
        wr_work = (dest_sel == maaf_pkg::DEST_WORK);
        wr_file = (dest_sel == maaf_pkg::DEST_FILE);
      end
      maaf_pkg::op_reg_and: begin
        nxt_result = work_ff & rf_bus.rd_data;
        upd_zero = 1'b1;
        wr_work = (dest_sel == maaf_pkg::DEST_WORK);
        wr_file = (dest_sel == maaf_pkg::DEST_FILE);
      end
      maaf_pkg::op_bit_clear: begin
        nxt_result = rf_bus.rd_data & ~(8'h01 << bit_sel);
        wr_file = 1'b1;
      end
      maaf_pkg::op_ctrl_page_write: begin
        nxt_result = work_ff;
        bad_addr = (page_addr < maaf_pkg::CTRL_PAGE_FIRST)
                 || (page_addr > maaf_pkg::CTRL_PAGE_LAST);
        wr_ctrl = ~bad_addr;
      end
      maaf_pkg::op_ctrl_page_read: begin
        nxt_result = ctrl_page_ff[page_addr];
        bad_addr = (page_addr < maaf_pkg::CTRL_PAGE_FIRST)
                 || (page_addr > maaf_pkg::CTRL_PAGE_LAST);
        wr_work = ~bad_addr;
      end
      maaf_pkg::op_sfr_page_write: begin
        nxt_result = work_ff;
        bad_addr = (page_addr < maaf_pkg::SFR_PAGE_FIRST)
                 || (page_addr > maaf_pkg::SFR_PAGE_LAST);
        wr_sfr = ~bad_addr;
      end
      maaf_pkg::op_sfr_page_read: begin
        nxt_result = sfr_page_ff[page_addr];
        wr_work = 1'b1;
      end
      default: begin
        nxt_result = work_ff;
      end
    endcase
  end

  // ----------------------------------------
  // destination writes
  // ----------------------------------------
  assign rf_bus.wr_en = take & wr_file;
  assign rf_bus.wr_addr = file_addr;
  assign rf_bus.wr_data = nxt_result;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      work_ff <= maaf_pkg::WORK_RESET;
    end else if (take & wr_work) begin
      work_ff <= nxt_result;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < PAGE_DEPTH; i++) begin
        ctrl_page_ff[i] <= maaf_pkg::FILE_RESET;
        sfr_page_ff[i] <= maaf_pkg::FILE_RESET;
      end
    end else begin
      if (take & wr_ctrl) begin
        ctrl_page_ff[page_addr] <= nxt_result;
      end
      if (take & wr_sfr) begin
        sfr_page_ff[page_addr] <= nxt_result;
      end
    end
  end

  // ----------------------------------------
  // arithmetic flags
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      carry_ff <= maaf_pkg::ARITH_FLAG_RESET;
      digit_carry_ff <= maaf_pkg::ARITH_FLAG_RESET;
    end else if (take & upd_arith) begin
      carry_ff <= add_c;
      digit_carry_ff <= add_dc;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      zero_ff <= maaf_pkg::ARITH_FLAG_RESET;
    end else if (take & (upd_arith | upd_zero)) begin
      zero_ff <= maaf_pkg::maaf_is_zero(nxt_result);
    end
  end

  // ----------------------------------------
  // power and watchdog status
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_down_ff <= maaf_pkg::POWER_DOWN_RESET;
    end else if (take & (op_code == maaf_pkg::op_watchdog_clear)) begin
      power_down_ff <= 1'b1;
    end else if (take & (op_code == maaf_pkg::op_halt)) begin
      power_down_ff <= 1'b0;
    end
  end

  // timeout beats an instruction in the same cycle so the event is never lost
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      time_out_ff <= maaf_pkg::TIME_OUT_RESET;
    end else if (timeout_event) begin
      time_out_ff <= 1'b0;
    end else if (take & ((op_code == maaf_pkg::op_watchdog_clear)
                      | (op_code == maaf_pkg::op_halt))) begin
      time_out_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // halt mode
  // ----------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      maaf_pkg::mode_run: begin
        if (take & (op_code == maaf_pkg::op_halt)) begin
          nxt_mode = maaf_pkg::mode_halt;
        end
      end
      maaf_pkg::mode_halt: begin
        if (timeout_event | wake_event) begin
          nxt_mode = maaf_pkg::mode_run;
        end
      end
      default: begin
        nxt_mode = maaf_pkg::mode_run;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_ff <= maaf_pkg::mode_run;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ----------------------------------------
  // completion report
  // ----------------------------------------
  // every operation here completes in the cycle it is taken
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_ff <= 1'b0;
      reject_ff <= 1'b0;
      result_ff <= maaf_pkg::WORK_RESET;
    end else begin
      done_ff <= take;
      reject_ff <= take & bad_addr;
      if (take) begin
        result_ff <= nxt_result;
      end
    end
  end

  assign work_register = work_ff;
  assign carry_flag = carry_ff;
  assign zero_flag = zero_ff;
  assign digit_carry_flag = digit_carry_ff;
  assign power_down_flag = power_down_ff;
  assign time_out_flag = time_out_ff;
  assign halted = (mode_ff == maaf_pkg::mode_halt);
  assign op_done = done_ff;
  assign op_reject = reject_ff;
  assign result_data = result_ff;

endmodule : maaf_top

`default_nettype wire
